// ==== fbpi_process_image.sv ====
// Top of the fieldbus drive process image: takes the short output image,
// drives the run commands, runs the message area and builds the input image.
// Assumes the fieldbus controller strobes out_valid when a new output image
// arrives and that the drive answers each message on its own port.

`timescale 1ns/100ps
`default_nettype none

module fbpi_process_image #(
	parameter int MSG_MAX_BYTES = fbpi_pkg::MSG_MAX_BYTES
) (
	// Clock, reset, enable
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	input  wire logic                 ce,
	// Output image from the master
	input  wire fbpi_pkg::fbpi_image_s out_image,
	input  wire logic                 out_valid,
	// Input image to the master
	output fbpi_pkg::fbpi_image_s     in_image,
	// Drive settings
	input  wire logic                 run_command_method_select,
	input  wire logic [3:0]           control_method_select,
	// Drive run commands
	output fbpi_pkg::fbpi_cmd_s       cmd,
	output logic [15:0]               freq_reference,
	// Drive state
	input  wire fbpi_pkg::fbpi_state_s drive_state_monitor,
	input  wire logic [15:0]          motor_speed,
	input  wire logic [15:0]          output_frequency,
	// Message port toward the drive
	output logic                      msg_valid,
	input  wire logic                 msg_ready,
	output logic                      msg_write,
	output logic [15:0]               msg_addr,
	output logic [7:0]                msg_len,
	output logic [15:0]               msg_wdata,
	input  wire logic                 rsp_valid,
	input  wire logic                 rsp_error,
	input  wire logic [15:0]          rsp_rdata
);

	// Refused at elaboration: the length check only serves even 2..8
	if (MSG_MAX_BYTES < 2 || MSG_MAX_BYTES > fbpi_pkg::MSG_MAX_BYTES ||
		MSG_MAX_BYTES % 2 != 0) begin : g_bad_max_bytes
		$error("MSG_MAX_BYTES must be even and within 2..8");
	end

	localparam logic [7:0] MAX_LEN = 8'(MSG_MAX_BYTES);

	// Latched output image
	logic [15:0]           run_control_word;
	logic [15:0]           freq_ref_q;
	logic [7:0]            func_q;
	logic [15:0]           addr_q;
	logic [7:0]            len_q;
	logic [15:0]           data_q;
	logic [7:0]            hshk_out_q;

	// Message engine
	fbpi_pkg::fbpi_msg_e   state_q;
	fbpi_pkg::fbpi_msg_e   state_d;
	logic [7:0]            last_hshk_q;
	logic [7:0]            rep_func_q;
	logic [15:0]           rep_addr_q;
	logic [7:0]            rep_len_q;
	logic [15:0]           rep_data_q;
	logic [7:0]            rep_hshk_q;
	logic                  new_msg;
	logic                  len_ok;
	logic                  is_write;
	logic [15:0]           drive_state_word;
	logic [15:0]           speed_field;

	function automatic logic [7:0] err_code(input logic [7:0] fc);
		err_code = (fc == fbpi_pkg::FC_WRITE) ? fbpi_pkg::FC_WRITE_ERR :
			(fc == fbpi_pkg::FC_READ) ? fbpi_pkg::FC_READ_ERR :
			(fc | fbpi_pkg::FC_ERR_FLAG);
	endfunction

	// Output image capture
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			run_control_word <= fbpi_pkg::WORD_RST;
			freq_ref_q <= fbpi_pkg::WORD_RST;
			func_q <= fbpi_pkg::BYTE_RST;
			addr_q <= fbpi_pkg::WORD_RST;
			len_q <= fbpi_pkg::BYTE_RST;
			data_q <= fbpi_pkg::WORD_RST;
			hshk_out_q <= fbpi_pkg::BYTE_RST;
		end else if (ce && out_valid) begin
			// Reserved byte 10 of the output image is dropped
			run_control_word <= out_image.word;
			freq_ref_q <= out_image.value;
			func_q <= out_image.func;
			addr_q <= out_image.addr;
			len_q <= out_image.len;
			data_q <= out_image.data;
			hshk_out_q <= out_image.hshk;
		end
	end

	assign freq_reference = freq_ref_q;

	fbpi_ctrl_decode u_decode (
		.sys_clk                   (sys_clk),
		.rst_b                     (rst_b),
		.ce                        (ce),
		.run_control_word          (run_control_word),
		.run_command_method_select (run_command_method_select),
		.cmd                       (cmd)
	);

	// A new message is marked by the master changing its handshake byte
	assign new_msg = (hshk_out_q != last_hshk_q);
	assign is_write = (func_q == fbpi_pkg::FC_WRITE);
	// Odd, zero or oversized counts are refused outright
	assign len_ok = (len_q != 8'h00) && !len_q[0] &&
		(len_q <= MAX_LEN);

	// Message state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			fbpi_pkg::MSG_IDLE: begin
				if (new_msg && fbpi_pkg::fc_supported(func_q) && len_ok &&
					func_q != fbpi_pkg::FC_LOOP)
					state_d = fbpi_pkg::MSG_ISSUE;
			end
			fbpi_pkg::MSG_ISSUE: begin
				if (msg_ready)
					state_d = fbpi_pkg::MSG_WAIT;
			end
			fbpi_pkg::MSG_WAIT: begin
				if (rsp_valid)
					state_d = fbpi_pkg::MSG_REPLY;
			end
			fbpi_pkg::MSG_REPLY: begin
				state_d = fbpi_pkg::MSG_IDLE;
			end
			default: begin
				state_d = fbpi_pkg::MSG_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			state_q <= fbpi_pkg::MSG_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	// Handshake bookkeeping: the reply handshake echoes the accepted one
	// only once the reply fields are final, so the master never pairs a
	// stale reply with a new request
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			last_hshk_q <= fbpi_pkg::BYTE_RST;
			rep_hshk_q <= fbpi_pkg::BYTE_RST;
		end else if (ce) begin
			if (state_q == fbpi_pkg::MSG_IDLE && new_msg)
				last_hshk_q <= hshk_out_q;
			if (state_q == fbpi_pkg::MSG_IDLE && new_msg &&
				state_d == fbpi_pkg::MSG_IDLE)
				rep_hshk_q <= hshk_out_q;
			else if (state_q == fbpi_pkg::MSG_REPLY)
				rep_hshk_q <= last_hshk_q;
		end
	end

	// Reply fields
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rep_func_q <= fbpi_pkg::FC_WAIT;
			rep_addr_q <= fbpi_pkg::WORD_RST;
			rep_len_q <= fbpi_pkg::BYTE_RST;
			rep_data_q <= fbpi_pkg::WORD_RST;
		end else if (ce) begin
			if (state_q == fbpi_pkg::MSG_IDLE && new_msg) begin
				rep_addr_q <= addr_q;
				rep_len_q <= len_q;
				if (!fbpi_pkg::fc_supported(func_q) || !len_ok) begin
					rep_func_q <= err_code(func_q);
					rep_data_q <= fbpi_pkg::WORD_RST;
				end else if (func_q == fbpi_pkg::FC_LOOP) begin
					rep_func_q <= func_q;
					rep_data_q <= data_q;
				end else begin
					rep_func_q <= fbpi_pkg::FC_WAIT;
				end
			end else if (state_q == fbpi_pkg::MSG_WAIT && rsp_valid) begin
				if (rsp_error) begin
					rep_func_q <= err_code(func_q);
					rep_data_q <= fbpi_pkg::WORD_RST;
				end else begin
					rep_func_q <= is_write ? fbpi_pkg::FC_WRITE :
						fbpi_pkg::FC_READ;
					rep_data_q <= is_write ? data_q : rsp_rdata;
				end
			end
		end
	end

	// Request held stable toward the drive while it is offered
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_write <= 1'b0;
			msg_addr <= fbpi_pkg::WORD_RST;
			msg_len <= fbpi_pkg::BYTE_RST;
			msg_wdata <= fbpi_pkg::WORD_RST;
		end else if (ce && state_q == fbpi_pkg::MSG_IDLE && new_msg) begin
			msg_write <= is_write;
			msg_addr <= addr_q;
			msg_len <= len_q;
			msg_wdata <= data_q;
		end
	end

	assign msg_valid = (state_q == fbpi_pkg::MSG_ISSUE);

	// Drive state word, bit 0 in the lowest field
	assign drive_state_word = drive_state_monitor;

	// Open-loop modes have no measured speed to give
	assign speed_field =
		(control_method_select == fbpi_pkg::CM_VF ||
		control_method_select == fbpi_pkg::CM_OPEN_LOOP_PM) ?
		output_frequency : motor_speed;

	// Input image
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			in_image <= '0;
		end else if (ce) begin
			in_image.word <= drive_state_word;
			in_image.value <= speed_field;
			in_image.func <= rep_func_q;
			in_image.addr <= rep_addr_q;
			in_image.len <= rep_len_q;
			in_image.data <= rep_data_q;
			in_image.rsvd <= fbpi_pkg::BYTE_RST;
			in_image.hshk <= rep_hshk_q;
		end
	end

endmodule

`default_nettype wire

// ==== fbpi_defs.sv ====
// Shared constants and carriers for the fieldbus drive process image,
// plus the run control word decoder.
// Assumes one clock, sys_clk, with a synchronous active-low reset.
//
// Notes on behaviour
// - Bit 0: forward run, or run/stop.
// - Bit 1: reverse run, or direction reverse.
// - Bits 2-7 become digital inputs 3-8.
// - Bit 8 raises network external fault.
// - Bit 9 requests a fault reset.
// - Rising edge of bit E clears traces.
// - Bit F high holds external baseblock.
// - State bits 0-3: run, zero, reverse, reset.
// - State bits 4-7: agree, ready, alarm, fault.
// - State bit 8 setting error, 9 power loss.
// - State bits A-F: net, relay, photo, motor2, servo.
// - Output image: 12 bytes, fixed byte layout.
// - Input image: state, speed, message, handshake.
// - V/f or open-loop PM reports output frequency.
// - At most four data items per message.
// - Function codes 03, 08, 10; others unsupported.
// - Reply 00 waiting, echo, 83 or 90 error; other codes error with bit 7 set.

`timescale 1ns/100ps
`default_nettype none

package fbpi_pkg;

	// Image geometry
	localparam int IMAGE_BYTES = 12;
	localparam int WORD_BITS = 16;
	localparam int MSG_MAX_BYTES = 8;

	// Control word bit positions
	localparam int CW_RUN = 0;
	localparam int CW_REV = 1;
	localparam int CW_DIN_LO = 2;
	localparam int CW_DIN_HI = 7;
	localparam int CW_EXT_FAULT = 8;
	localparam int CW_FAULT_RST = 9;
	localparam int CW_TRACE_CLR = 14;
	localparam int CW_BASEBLOCK = 15;

	// Message function and reply codes
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_LOOP = 8'h08;
	localparam logic [7:0] FC_WRITE = 8'h10;
	localparam logic [7:0] FC_WAIT = 8'h00;
	localparam logic [7:0] FC_READ_ERR = 8'h83;
	localparam logic [7:0] FC_WRITE_ERR = 8'h90;
	localparam logic [7:0] FC_ERR_FLAG = 8'h80;

	// Control method codes that report output frequency as speed
	localparam logic [3:0] CM_VF = 4'h0;
	localparam logic [3:0] CM_OPEN_LOOP_PM = 4'h5;

	// Reset values
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Byte 0 sits in the top bits, so the struct reads in image order
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] value;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [7:0]  len;
		logic [15:0] data;
		logic [7:0]  rsvd;
		logic [7:0]  hshk;
	} fbpi_image_s;

	typedef struct packed {
		logic       forward_run_request;
		logic       reverse_run_request;
		logic [5:0] dig_in;
		logic       network_external_fault;
		logic       fault_reset;
		logic       trace_clear;
		logic       baseblock;
	} fbpi_cmd_s;

	// Bit 0 of the drive state word is the lowest field
	typedef struct packed {
		logic zero_servo_done;
		logic motor2_sel;
		logic photo2_closed;
		logic photo1_closed;
		logic relay_closed;
		logic network_control_active;
		logic power_loss;
		logic operation_setting_error;
		logic fault;
		logic alarm;
		logic ready;
		logic speed_agree;
		logic fault_reset_in;
		logic reverse_running;
		logic zero_speed;
		logic running;
	} fbpi_state_s;

	typedef enum logic [3:0] {
		MSG_IDLE  = 4'b0001,
		MSG_ISSUE = 4'b0010,
		MSG_WAIT  = 4'b0100,
		MSG_REPLY = 4'b1000
	} fbpi_msg_e;

	function automatic logic fc_supported(input logic [7:0] fc);
		fc_supported = (fc == FC_READ) || (fc == FC_LOOP) ||
			(fc == FC_WRITE);
	endfunction

endpackage

module fbpi_ctrl_decode (
	// Clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	// Control word and its setting
	input  wire logic [15:0]       run_control_word,
	input  wire logic              run_command_method_select,
	// Decoded commands
	output fbpi_pkg::fbpi_cmd_s    cmd
);

	logic clr_prev_q;
	logic b0;
	logic b1;

	assign b0 = run_control_word[fbpi_pkg::CW_RUN];
	assign b1 = run_control_word[fbpi_pkg::CW_REV];

	// Bits A to D are reserved and never looked at
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cmd <= '0;
			clr_prev_q <= 1'b0;
		end else if (ce) begin
			if (!run_command_method_select) begin
				cmd.forward_run_request <= b0;
				cmd.reverse_run_request <= b1;
			end else begin
				cmd.forward_run_request <= b0 & ~b1;
				cmd.reverse_run_request <= b0 & b1;
			end
			cmd.dig_in <= run_control_word[fbpi_pkg::CW_DIN_HI:
				fbpi_pkg::CW_DIN_LO];
			cmd.network_external_fault <=
				run_control_word[fbpi_pkg::CW_EXT_FAULT];
			cmd.fault_reset <=
				run_control_word[fbpi_pkg::CW_FAULT_RST];
			clr_prev_q <= run_control_word[fbpi_pkg::CW_TRACE_CLR];
			// One pulse per edge; a held bit must not keep clearing
			cmd.trace_clear <= run_control_word[fbpi_pkg::CW_TRACE_CLR] &
				~clr_prev_q;
			cmd.baseblock <=
				run_control_word[fbpi_pkg::CW_BASEBLOCK];
		end
	end

endmodule

`default_nettype wire

// ==== fbpi_process_image_checker.sv ====
// Concurrent checks on the ports of the process image top.
// Assumes ce stays high while a checked relation is in flight.
`timescale 1ns/100ps
`default_nettype none
module fbpi_process_image_checker (
	// Clock, reset, enable
	input wire logic                  sys_clk,
	input wire logic                  rst_b,
	input wire logic                  ce,
	// Images and settings
	input wire fbpi_pkg::fbpi_image_s out_image,
	input wire logic                  out_valid,
	input wire fbpi_pkg::fbpi_image_s in_image,
	input wire logic                  run_command_method_select,
	input wire logic [3:0]            control_method_select,
	// Drive side
	input wire fbpi_pkg::fbpi_cmd_s   cmd,
	input wire fbpi_pkg::fbpi_state_s drive_state_monitor,
	input wire logic [15:0]           motor_speed,
	input wire logic [15:0]           output_frequency,
	input wire logic                  msg_valid,
	input wire logic                  msg_ready,
	input wire logic                  msg_write,
	input wire logic [15:0]           msg_addr,
	input wire logic                  rsp_valid,
	input wire logic                  rsp_error
);
	logic [15:0] spd_sel;
	logic [7:0]  fc_exp;
	assign spd_sel = (control_method_select == fbpi_pkg::CM_VF ||
		control_method_select == fbpi_pkg::CM_OPEN_LOOP_PM) ?
		output_frequency : motor_speed;
	assign fc_exp = rsp_error ? (msg_write ? 8'h90 : 8'h83) :
		(msg_write ? 8'h10 : 8'h03);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_take;
		ce && out_valid ##1 ce;
	endsequence
	sequence s_fresh;
		$past(rst_b) && $past(ce);
	endsequence
	a_state_word_mirror: assert property (s_fresh |-> in_image.word ==
		$past(drive_state_monitor)) else $error("state word lag");
	a_speed_field_select: assert property (s_fresh |-> in_image.value ==
		$past(spd_sel)) else $error("speed field wrong");
	a_reserved_byte_zero: assert property (in_image.rsvd == 8'h00)
		else $error("reserved byte not zero");
	a_run_bits_decode: assert property (s_take |=>
		cmd.forward_run_request == (run_command_method_select ?
		$past(out_image.word[0], 2) && !$past(out_image.word[1], 2) :
		$past(out_image.word[0], 2))) else $error("run decode");
	a_input_bits_pass: assert property (s_take |=> cmd.dig_in ==
		$past(out_image.word[7:2], 2)) else $error("digital inputs");
	a_fault_block_bits: assert property (s_take |=> {cmd.baseblock,
		cmd.fault_reset, cmd.network_external_fault} ==
		{$past(out_image.word[15], 2), $past(out_image.word[9:8], 2)})
		else $error("fault or baseblock bits");
	a_trace_one_pulse: assert property (cmd.trace_clear |->
		$past(out_valid, 2) && $past(out_image.word[14], 2)
		##1 !cmd.trace_clear) else $error("trace clear pulse");
	a_request_held: assert property (msg_valid && !msg_ready |=> msg_valid
		&& $stable(msg_addr) && $stable(msg_write))
		else $error("request dropped");
	a_wait_code: assert property ($rose(msg_valid) |=>
		in_image.func == fbpi_pkg::FC_WAIT) else $error("no wait code");
	a_reply_code: assert property (rsp_valid |-> ##2 in_image.func ==
		$past(fc_exp, 2)) else $error("reply code wrong");
endmodule
bind fbpi_process_image fbpi_process_image_checker u_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .out_image(out_image),
	.out_valid(out_valid), .in_image(in_image),
	.run_command_method_select(run_command_method_select),
	.control_method_select(control_method_select), .cmd(cmd),
	.drive_state_monitor(drive_state_monitor), .motor_speed(motor_speed),
	.output_frequency(output_frequency), .msg_valid(msg_valid),
	.msg_ready(msg_ready), .msg_write(msg_write), .msg_addr(msg_addr),
	.rsp_valid(rsp_valid), .rsp_error(rsp_error));
`default_nettype wire

// ==== fbpi_drive_model.sv ====
// Behavioural drive at the message port: takes a request, answers later.
// Assumes the bench sets lag and err before each message.
`timescale 1ns/100ps
`default_nettype none
module fbpi_drive_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Bench controls
	input  wire logic [3:0]  lag,
	input  wire logic        err,
	// Request from the option
	input  wire logic        msg_valid,
	input  wire logic [15:0] msg_addr,
	output logic             msg_ready,
	// Answer to the option
	output logic             rsp_valid,
	output logic             rsp_error,
	output logic [15:0]      rsp_rdata
);
	logic [2:0]  st;
	logic [3:0]  cnt;
	logic [15:0] addr;
	always @(posedge sys_clk) begin
		// Answer lines flip every cycle out of reset except the one that loads an answer, so stale data is never mistaken
		rsp_rdata <= ~rsp_rdata;
		rsp_error <= ~rsp_error;
		case (st)
			3'h0: if (msg_valid) begin
				cnt <= lag;
				addr <= msg_addr;
				st <= 3'h1;
			end
			3'h1: if (cnt == 4'h0) begin
				msg_ready <= 1'b1;
				st <= 3'h2;
			end else cnt <= cnt - 4'h1;
			3'h2: begin
				msg_ready <= 1'b0;
				cnt <= lag;
				st <= 3'h3;
			end
			3'h3: if (cnt == 4'h0) begin
				rsp_valid <= 1'b1;
				rsp_error <= err;
				rsp_rdata <= addr ^ 16'h5a5a;
				st <= 3'h4;
			end else cnt <= cnt - 4'h1;
			default: begin
				rsp_valid <= 1'b0;
				st <= 3'h0;
			end
		endcase
		if (!rst_b) begin
			st <= 3'h0;
			msg_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			rsp_rdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ==== fbpi_process_image_tb_top.sv ====
// Self-checking bench for the process image top with a behavioural drive.
// Assumes the package, design, checker and drive model compile first.
`timescale 1ns/100ps
`default_nettype none
module fbpi_process_image_tb_top;
	logic                  sys_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  ov = 1'b0, rsm = 1'b0, err = 1'b0;
	logic [3:0]            cms = 4'h0, lag = 4'h0;
	logic [15:0]           ms = 16'h0000, of = 16'h0000, pw = 16'h0000;
	logic [15:0]           fref, maddr, rd, mwd;
	logic [7:0]            hs = 8'h00;
	logic [7:0]            mlen;
	logic [31:0]           rr;
	logic                  mv, mr, rv, re, mw;
	logic [31:0]           seed = 32'h0000392c;
	int                    n_fail = 0, checks_done = 0, cyc = 0;
	fbpi_pkg::fbpi_image_s oimg = '0, iimg;
	fbpi_pkg::fbpi_state_s dsm = '0;
	fbpi_pkg::fbpi_cmd_s   cmd;
	fbpi_process_image uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1),
		.out_image(oimg), .out_valid(ov), .in_image(iimg),
		.run_command_method_select(rsm), .control_method_select(cms),
		.cmd(cmd), .freq_reference(fref), .drive_state_monitor(dsm),
		.motor_speed(ms), .output_frequency(of), .msg_valid(mv),
		.msg_ready(mr), .msg_write(mw), .msg_addr(maddr), .msg_len(mlen),
		.msg_wdata(mwd), .rsp_valid(rv), .rsp_error(re), .rsp_rdata(rd));
	fbpi_drive_model drv (.sys_clk(sys_clk), .rst_b(rst_b), .lag(lag),
		.err(err), .msg_valid(mv), .msg_addr(maddr), .msg_ready(mr),
		.rsp_valid(rv), .rsp_error(re), .rsp_rdata(rd));
	always #25 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] exp_cmd(logic [15:0] w, logic m);
		fbpi_pkg::fbpi_cmd_s c;
		c.forward_run_request = m ? w[0] & ~w[1] : w[0];
		c.reverse_run_request = m ? w[0] & w[1] : w[1];
		c.dig_in = w[7:2];
		c.network_external_fault = w[8];
		c.fault_reset = w[9];
		c.trace_clear = w[14] & ~pw[14];
		c.baseblock = w[15];
		return {4'h0, c};
	endfunction
	function automatic logic [7:0] exp_fc(logic [7:0] f, l, logic e);
		if (!(f inside {8'h03, 8'h08, 8'h10}))
			return f | 8'h80;
		if (l == 8'h00 || l[0] || l > 8'h08)
			return (f == 8'h03) ? 8'h83 : f | 8'h80;
		if (f == 8'h08)
			return f;
		return e ? f | 8'h80 : f;
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [15:0] w, input logic m,
		input logic [3:0] c);
		logic [31:0] r;
		@(negedge sys_clk);
		r = rnd();
		oimg.word = w;
		{oimg.value, oimg.rsvd} = r[23:0];
		{dsm, ms} = rnd();
		r = rnd();
		{rsm, cms, of} = {m, c, r[15:0]};
		ov = 1'b1;
		@(negedge sys_clk);
		ov = 1'b0;
		@(negedge sys_clk);
		chk({4'h0, cmd}, exp_cmd(w, m));
		chk(iimg.word, dsm);
		chk(iimg.value, (c == 4'h0 || c == 4'h5) ? of : ms);
		chk({8'h00, iimg.rsvd}, 16'h0000);
		chk(fref, oimg.value);
		@(negedge sys_clk);
		chk({15'h0, cmd.trace_clear}, 16'h0000);
		pw = w;
	endtask
	task automatic msg(input logic [7:0] f, l, input logic [3:0] d,
		input logic e);
		logic [7:0] x;
		@(negedge sys_clk);
		{lag, err, hs} = {d, e, hs + 8'h01};
		{oimg.func, oimg.len, oimg.hshk} = {f, l, hs};
		{oimg.addr, oimg.data} = rnd();
		ov = 1'b1;
		@(negedge sys_clk);
		ov = 1'b0;
		for (int k = 0; k < 200 && iimg.hshk !== hs; k++)
			@(negedge sys_clk);
		x = exp_fc(f, l, e);
		chk({8'h00, iimg.hshk}, {8'h00, hs});
		chk({8'h00, iimg.func}, {8'h00, x});
		chk(iimg.addr, oimg.addr);
		chk({8'h00, iimg.len}, {8'h00, l});
		chk({mw, 7'h00, mlen}, {f == 8'h10, 7'h00, l});
		chk(mwd, oimg.data);
		if (x == f)
			chk(iimg.data, (f == 8'h03) ? oimg.addr ^ 16'h5a5a :
				oimg.data);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		for (int i = 0; i < 32; i++) begin
			rr = rnd();
			put((i == 0) ? 16'hffff : (i == 1) ? 16'h4000 : rr[15:0],
				i[0], i[4:1]);
		end
		msg(8'h03, 8'h02, 4'h0, 1'b0);
		msg(8'h03, 8'h08, 4'h5, 1'b0);
		msg(8'h10, 8'h04, 4'h3, 1'b0);
		// Enter stand-in: a plain write after the parameter write
		msg(8'h10, 8'h02, 4'h1, 1'b0);
		msg(8'h10, 8'h02, 4'h0, 1'b1);
		msg(8'h03, 8'h06, 4'h2, 1'b1);
		msg(8'h08, 8'h02, 4'h0, 1'b0);
		msg(8'h08, 8'h00, 4'h0, 1'b0);
		msg(8'h06, 8'h02, 4'h0, 1'b0);
		msg(8'h10, 8'h0a, 4'h0, 1'b0);
		msg(8'h03, 8'h03, 4'h0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rr = rnd();
			msg(8'h03, 8'h02, rr[3:0], rr[4]);
		end
		summarize();
	end
endmodule
`default_nettype wire
